// ### shared/gfxcg_map.svh
`ifndef GFXCG_MAP_SVH
`define GFXCG_MAP_SVH
// register offsets on the bus slave window
`define GFXCG_OFS_TIMEOUT 8'h00
`define GFXCG_OFS_STATUS  8'h04
`define GFXCG_OFS_TILE_DATA 8'h08
// reset value of the idle timeout count
`define GFXCG_TIMEOUT_RST 16'h0040
// clock settling interval, in CLK_SYS cycles
`define GFXCG_SETTLE_CYC  3'h4
// tile accelerator input buffer
`define GFXCG_FIFO_W      32
`define GFXCG_FIFO_D      32
// command word fields
`define GFXCG_CMD_3D      31
`define GFXCG_CMD_WE      29
// most split transfers in flight on the memory port
`define GFXCG_MAX_OUT     3'h4
`endif

// ### shared/gfxcg_pkg.sv
package gfxcg_pkg;
   typedef enum logic [1:0] {
      ST_WATCH  = 2'b00,
      ST_SETTLE = 2'b01,
      ST_RUN    = 2'b11
   } gfxcg_state_t;
   typedef enum logic [1:0] {
      HR_OKAY  = 2'b00,
      HR_ERROR = 2'b01,
      HR_RETRY = 2'b10
   } gfxcg_hresp_t;
   typedef enum logic [1:0] {
      MD_ALL_OFF = 2'b00,
      MD_IDLE    = 2'b01,
      MD_2D      = 2'b10,
      MD_3D      = 2'b11
   } gfxcg_mode_t;
endpackage

// ### hw/gfxcg_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module gfxcg_fifo #(
   parameter int W = 32,
   parameter int D = 32
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 ce,
   input  wire logic                 in_valid,
   output logic                      in_ready,
   input  wire logic [W-1:0]         in_data,
   output logic                      out_valid,
   input  wire logic                 out_ready,
   output logic [W-1:0]              out_data,
   output logic [$clog2(D+1)-1:0]    level
);
   localparam int AW = $clog2(D);
   logic [W-1:0]            mem [D];
   logic [AW-1:0]           rd_ptr;
   logic [AW-1:0]           wr_ptr;
   logic [$clog2(D+1)-1:0]  next_level;
   logic                    push;
   logic                    pop;

   always_comb begin
      push       = in_valid && in_ready;
      pop        = out_valid && out_ready;
      next_level = level;
      if (push && !pop) begin
         next_level = level + 1'b1;
      end else if (pop && !push) begin
         next_level = level - 1'b1;
      end
   end

   assign in_ready  = (level != D[$clog2(D+1)-1:0]);
   assign out_valid = (level != '0);
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         level  <= '0;
      end else if (ce) begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
         end
         level <= next_level;
      end
   end

   // storage has no reset: it is only read below the level
   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ### hw/gfxcg_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "gfxcg_map.svh"
module gfxcg_top
   import gfxcg_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        RESET_N,
   input  wire logic        CE,
   input  wire logic        HSEL,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [7:0]  HADDR,
   input  wire logic        HREADY,
   input  wire logic [31:0] HWDATA,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic [1:0]       HRESP,
   output logic             GMP_REQ,
   output logic             GMP_WE,
   output logic [31:0]      GMP_ADDR,
   output logic [31:0]      GMP_WDATA,
   input  wire logic        GMP_ACK,
   input  wire logic        GMP_RVALID,
   input  wire logic        PWRDN_REQ,
   output logic             GATE_BUS,
   output logic             GATE_CORE,
   output logic             GATE_3D,
   output logic [1:0]       MODE
);
   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   logic         dp_valid, dp_write, resp_second, dp_gated;
   logic [7:0]   dp_addr;
   logic [1:0]   resp_code;
   logic [15:0]  timeout;
   logic         next_dp_valid, next_dp_write, next_resp_second, next_dp_gated;
   logic [7:0]   next_dp_addr;
   logic [1:0]   next_resp_code;
   logic [15:0]  next_timeout;
   logic [31:0]  next_hrdata;
   logic         ap, dp_err, dp_rty, bad, acc_ok, push;
   logic         fifo_in_ready, fifo_out_valid, pop;
   logic [31:0]  head;
   logic [5:0]   fifo_level;
   logic         bus_gated;
   logic [2:0]   outst;
   gfxcg_state_t state;

   always_comb begin
      ap       = HSEL && HTRANS[1] && HREADY;
      dp_err   = dp_valid && !(dp_addr == `GFXCG_OFS_TIMEOUT || dp_addr == `GFXCG_OFS_STATUS
                               || dp_addr == `GFXCG_OFS_TILE_DATA);
      // gate state latched with the address: the wake clears it at that same edge
      dp_rty   = dp_valid && !dp_err && (dp_gated || (dp_write
                 && dp_addr == `GFXCG_OFS_TILE_DATA && !fifo_in_ready));
      bad      = (dp_err || dp_rty) && !resp_second;
      acc_ok   = dp_valid && !dp_err && !dp_rty && !resp_second;
      push     = acc_ok && dp_write && dp_addr == `GFXCG_OFS_TILE_DATA;
      next_timeout = timeout;
      if (acc_ok && dp_write && dp_addr == `GFXCG_OFS_TIMEOUT) begin
         next_timeout = HWDATA[15:0];
      end
      next_resp_second = bad;
      next_resp_code   = dp_err ? HR_ERROR : HR_RETRY;
      next_dp_valid    = dp_valid;
      next_dp_gated    = dp_gated;
      next_dp_write    = dp_write;
      next_dp_addr     = dp_addr;
      next_hrdata      = HRDATA;
      if (!bad) begin
         next_dp_valid = ap;
         next_dp_write = HWRITE;
         next_dp_addr  = HADDR;
         next_dp_gated = bus_gated;
         next_hrdata   = 32'h0000_0000;
         if (ap && !HWRITE && HADDR == `GFXCG_OFS_TIMEOUT) begin
            next_hrdata = {16'h0000, timeout};
         end else if (ap && !HWRITE && HADDR == `GFXCG_OFS_STATUS) begin
            next_hrdata = {21'h000000, fifo_level, outst, MODE};
         end
      end
   end

   always_comb begin
      HREADYOUT = !bad;
      if (resp_second) begin
         HRESP = resp_code;
      end else if (bad) begin
         HRESP = dp_err ? HR_ERROR : HR_RETRY;
      end else begin
         HRESP = HR_OKAY;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         dp_valid    <= 1'b0;
         dp_write    <= 1'b0;
         dp_addr     <= 8'h00;
         dp_gated    <= 1'b0;
         resp_second <= 1'b0;
         resp_code   <= HR_OKAY;
         timeout     <= `GFXCG_TIMEOUT_RST;
         HRDATA      <= 32'h0000_0000;
      end else if (CE) begin
         dp_valid    <= next_dp_valid;
         dp_write    <= next_dp_write;
         dp_addr     <= next_dp_addr;
         dp_gated    <= next_dp_gated;
         resp_second <= next_resp_second;
         resp_code   <= next_resp_code;
         timeout     <= next_timeout;
         HRDATA      <= next_hrdata;
      end
   end

   gfxcg_fifo #(
      .W (`GFXCG_FIFO_W),
      .D (`GFXCG_FIFO_D)
   ) u_tile_fifo (
      .clk       (CLK_SYS),
      .rst_n     (RESET_N),
      .ce        (CE),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (HWDATA),
      .out_valid (fifo_out_valid),
      .out_ready (pop),
      .out_data  (head),
      .level     (fifo_level)
   );

   // ---------------------------------------------------------------
   // memory port master and idle gating
   // ---------------------------------------------------------------
   logic         need_core, need_3d;
   logic [2:0]   settle;
   logic [15:0]  cnt_core, cnt_3d;
   gfxcg_state_t next_state;
   logic         next_need_core, next_need_3d, next_bus_gated;
   logic [2:0]   next_settle, next_outst;
   logic [15:0]  next_cnt_core, next_cnt_3d;
   logic         next_req, next_we;
   logic [31:0]  next_addr, next_wdata;
   logic         act_core, act_3d, head_3d, fits;

   always_comb begin
      head_3d  = fifo_out_valid && head[`GFXCG_CMD_3D];
      fits     = !head[`GFXCG_CMD_3D] || need_3d;
      // consume only on running, settled clocks with room on the port
      pop      = fifo_out_valid && state == ST_RUN && need_core && fits
                 && (!GMP_REQ || GMP_ACK) && outst + {2'h0, GMP_REQ} < `GFXCG_MAX_OUT;
      act_core = fifo_out_valid || GMP_REQ || outst != 3'h0 || HSEL;
      act_3d   = head_3d;
      next_req   = GMP_REQ && !GMP_ACK;
      next_we    = GMP_WE;
      next_addr  = GMP_ADDR;
      next_wdata = GMP_WDATA;
      if (pop) begin
         next_req   = 1'b1;
         next_we    = head[`GFXCG_CMD_WE];
         next_addr  = {3'h0, head[28:0]};
         next_wdata = head;
      end
      next_outst = outst + {2'h0, GMP_REQ && GMP_ACK} - {2'h0, GMP_RVALID && outst != 3'h0};
      next_state     = state;
      next_need_core = need_core;
      next_need_3d   = need_3d;
      next_settle    = settle;
      next_cnt_core  = cnt_core;
      next_cnt_3d    = cnt_3d;
      unique case (state)
         ST_WATCH: begin
            if (fifo_out_valid) begin
               next_need_core = 1'b1;
               next_need_3d   = head[`GFXCG_CMD_3D];
               next_settle    = `GFXCG_SETTLE_CYC - 3'h1;
               next_state     = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            next_settle = settle - 3'h1;
            if (settle == 3'h0) begin
               next_cnt_core = timeout;
               next_cnt_3d   = timeout;
               next_state    = ST_RUN;
            end
         end
         ST_RUN: begin
            if (head_3d && !need_3d) begin
               // 3D work behind a gated 3D clock: ungate and settle again
               next_need_3d = 1'b1;
               next_settle  = `GFXCG_SETTLE_CYC - 3'h1;
               next_state   = ST_SETTLE;
            end else begin
               if (act_core) begin
                  next_cnt_core = timeout;
               end else if (cnt_core != 16'h0000) begin
                  next_cnt_core = cnt_core - 16'h0001;
               end else begin
                  next_need_core = 1'b0;
                  next_need_3d   = 1'b0;
                  next_state     = ST_WATCH;
               end
               if (act_3d) begin
                  next_cnt_3d = timeout;
               end else if (cnt_3d != 16'h0000) begin
                  next_cnt_3d = cnt_3d - 16'h0001;
               end else begin
                  next_need_3d = 1'b0;
               end
            end
         end
         default: begin
            next_state = ST_WATCH;
         end
      endcase
      // bus clock is only given up with nothing pending at all
      next_bus_gated = bus_gated;
      if (HSEL || !PWRDN_REQ) begin
         next_bus_gated = 1'b0;
      end else if (state == ST_WATCH && !fifo_out_valid && !dp_valid) begin
         next_bus_gated = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         state     <= ST_WATCH;
         need_core <= 1'b0;
         need_3d   <= 1'b0;
         settle    <= 3'h0;
         cnt_core  <= 16'h0000;
         cnt_3d    <= 16'h0000;
         bus_gated <= 1'b0;
         outst     <= 3'h0;
         GMP_REQ   <= 1'b0;
         GMP_WE    <= 1'b0;
         GMP_ADDR  <= 32'h0000_0000;
         GMP_WDATA <= 32'h0000_0000;
      end else if (CE) begin
         state     <= next_state;
         need_core <= next_need_core;
         need_3d   <= next_need_3d;
         settle    <= next_settle;
         cnt_core  <= next_cnt_core;
         cnt_3d    <= next_cnt_3d;
         bus_gated <= next_bus_gated;
         outst     <= next_outst;
         GMP_REQ   <= next_req;
         GMP_WE    <= next_we;
         GMP_ADDR  <= next_addr;
         GMP_WDATA <= next_wdata;
      end
   end

   assign GATE_BUS  = bus_gated;
   assign GATE_CORE = !need_core;
   assign GATE_3D   = !need_3d;
   assign MODE      = bus_gated ? MD_ALL_OFF : !need_core ? MD_IDLE
                      : !need_3d ? MD_2D : MD_3D;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N || !CE);

   sequence s_retry_first;
      !HREADYOUT && HRESP == HR_RETRY;
   endsequence
   sequence s_settle_entry;
      state != ST_SETTLE ##1 state == ST_SETTLE;
   endsequence

   a_push_has_room: assert property (push |-> fifo_in_ready)
      else $error("geometry pushed into a full buffer");
   a_retry_two_cycle: assert property (s_retry_first |=> HREADYOUT && HRESP == HR_RETRY)
      else $error("retry answer not two cycles long");
   a_settle_length: assert property (s_settle_entry |-> (state == ST_SETTLE)[*4]
      ##1 state == ST_RUN)
      else $error("settling interval has wrong length");
   a_no_pop_gated: assert property (pop |-> state == ST_RUN && !GATE_CORE
      && (!head[`GFXCG_CMD_3D] || !GATE_3D))
      else $error("instruction consumed on a gated clock");
   a_reload_on_act: assert property (state == ST_RUN && act_core && !(head_3d && !need_3d)
      |=> cnt_core == $past(timeout))
      else $error("idle counter not reloaded on activity");
   a_idle_decrement: assert property (state == ST_RUN && !act_core && cnt_core != 16'h0000
      && !head_3d |=> cnt_core == $past(cnt_core) - 16'h0001)
      else $error("idle counter did not step down");
   a_gate_on_expiry: assert property (state == ST_RUN && !act_core && cnt_core == 16'h0000
      |=> state == ST_WATCH && GATE_CORE && GATE_3D)
      else $error("clocks not gated at idle expiry");
   a_mode_order: assert property (!GATE_3D |-> !GATE_CORE && MODE == MD_3D)
      else $error("3D clock running without core clock");
   a_port_in_flight: assert property (outst <= `GFXCG_MAX_OUT)
      else $error("too many split transfers in flight");
   a_decode_wakes: assert property (state == ST_WATCH && fifo_out_valid
      |=> state == ST_SETTLE && !GATE_CORE && GATE_3D == !$past(head[`GFXCG_CMD_3D]))
      else $error("decoded instruction did not request its clocks");
endmodule
`default_nettype wire

// ### verif/gfxcg_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// memory controller slave, slow or prompt
// ----------------------------------------
module gfxcg_mem_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        stall,
   input  wire logic        req,
   input  wire logic        we,
   input  wire logic [31:0] addr,
   input  wire logic [31:0] wdata,
   output logic             ack,
   output logic             rvalid
);
   logic [64:0] got[$];
   int          pend;
   int          seed = 7;
   int          n;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
         rvalid <= 1'b0;
         pend = 0;
      end else begin
         n = pend;
         if (req && ack) begin
            got.push_back({we, addr, wdata});
            n = n + 1;
         end
         // ack lags one cycle so a held request is never taken twice
         ack <= req && !ack && !stall && ($random(seed) % 4 != 0);
         rvalid <= 1'b0;
         if (n > 0 && !stall && ($random(seed) % 3 == 0)) begin
            rvalid <= 1'b1;
            n = n - 1;
         end
         pend = n;
      end
   end
endmodule
`default_nettype wire

// ### verif/gfxcg_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "gfxcg_map.svh"
module gfxcg_tb_top import gfxcg_pkg::*;;
   logic        clk_sys, reset_n, hsel, hwrite, stall, pwrdn, gack, grv, ce;
   logic        hready, greq, gwe, gate_bus, gate_core, gate_3d, gc_q = 1'b1;
   logic [1:0]  htrans, hresp, mode, rs;
   logic [7:0]  haddr;
   logic [31:0] hwdata, hrdata, gaddr, gwdata, rd, w, tmo;
   logic [31:0] exp_q[$];
   int          err_count, compares, seed, n, k, idle;
   gfxcg_top dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .CE(ce), .HSEL(hsel),
      .HTRANS(htrans), .HWRITE(hwrite), .HADDR(haddr), .HREADY(hready), .HWDATA(hwdata),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .GMP_REQ(greq), .GMP_WE(gwe),
      .GMP_ADDR(gaddr), .GMP_WDATA(gwdata), .GMP_ACK(gack), .GMP_RVALID(grv),
      .PWRDN_REQ(pwrdn), .GATE_BUS(gate_bus), .GATE_CORE(gate_core), .GATE_3D(gate_3d),
      .MODE(mode));
   gfxcg_mem_model mem (.clk(clk_sys), .rst_n(reset_n), .stall(stall), .req(greq),
      .we(gwe), .addr(gaddr), .wdata(gwdata), .ack(gack), .rvalid(grv));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [64:0] got, input logic [64:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wt(ref logic s, input logic v);
      n = 0;
      while (s !== v && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 2000) begin
         err_count++;
         wrap_up();
      end
   endtask
   // one transfer; leaves at the negedge where the data phase completes
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= a;
      @(posedge clk_sys);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      k = 0;
      @(negedge clk_sys);
      while (hready !== 1'b1 && k < 8) begin
         k++;
         @(negedge clk_sys);
      end
      if (k >= 8) begin
         err_count++;
         wrap_up();
      end
      rd = hrdata;
      rs = hresp;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      do begin
         ahb(1'b1, a, d);
         t++;
      end while (rs === HR_RETRY && t < 300);
      chk(rs, HR_OKAY);
      if (a == `GFXCG_OFS_TILE_DATA) exp_q.push_back(d);
   endtask
   // ----------------------------------------
   // monitors: idle timeout and outstanding limit
   // ----------------------------------------
   always @(negedge clk_sys) begin
      idle <= (greq || grv || hsel) ? 0 : idle + 1;
      gc_q <= gate_core;
      if (gate_core && !gc_q) chk(idle >= tmo && idle <= tmo + 4, 1'b1);
      chk(mem.pend + grv <= `GFXCG_MAX_OUT, 1'b1);
   end
   initial begin
      #800000;
      err_count++;
      wrap_up();
   end
   initial begin
      seed = 32'ha2be;
      {reset_n, hsel, htrans, hwrite, haddr, hwdata, stall, pwrdn} = '0;
      ce = 1'b1;
      tmo = 32'h8 + ($random(seed) & 32'h7);
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(negedge clk_sys);
      chk({gate_bus, gate_core, gate_3d, mode, hready, hresp, greq},
          {3'b011, MD_IDLE, 1'b1, HR_OKAY, 1'b0});
      ahb(1'b0, `GFXCG_OFS_TIMEOUT, 32'h0);
      chk(rd, `GFXCG_TIMEOUT_RST);
      wr(`GFXCG_OFS_TIMEOUT, tmo);
      wr(`GFXCG_OFS_STATUS, 32'hFFFF_FFFF);
      ahb(1'b0, `GFXCG_OFS_TIMEOUT, 32'h0);
      chk(rd, tmo);
      ahb(1'b1, 8'h0C, 32'h0);
      chk({k[1:0], rs}, {2'h1, HR_ERROR});
      for (int i = 0; i < 2; i++) begin
         w = $random(seed);
         w[31] = i[0];
         wr(`GFXCG_OFS_TILE_DATA, w);
         wt(gate_core, 1'b0);
         chk({gate_3d, mode}, {~i[0], i[0] ? MD_3D : MD_2D});
         wt(greq, 1'b1);
         chk(n >= `GFXCG_SETTLE_CYC, 1'b1);
         wt(gate_core, 1'b1);
         chk({gate_3d, mode}, {1'b1, MD_IDLE});
      end
      // far side stalled: fill until refused, then repeat the refused word
      stall <= 1'b1;
      n = 0;
      do begin
         w = $random(seed);
         ahb(1'b1, `GFXCG_OFS_TILE_DATA, w);
         if (rs === HR_OKAY) begin
            exp_q.push_back(w);
            n++;
         end
      end while (rs === HR_OKAY && n < 40);
      chk({rs, n >= `GFXCG_FIFO_D && n <= `GFXCG_FIFO_D + 2}, {HR_RETRY, 1'b1});
      stall <= 1'b0;
      wr(`GFXCG_OFS_TILE_DATA, w);
      // drain first, so the stalled bursts below never meet a full buffer
      wt(gate_core, 1'b1);
      repeat (24) begin
         stall <= $random(seed) % 2;
         wr(`GFXCG_OFS_TILE_DATA, $random(seed));
      end
      stall <= 1'b0;
      wt(gate_core, 1'b1);
      pwrdn <= 1'b1;
      wt(gate_bus, 1'b1);
      chk(mode, MD_ALL_OFF);
      w = $random(seed);
      ahb(1'b1, `GFXCG_OFS_TILE_DATA, w);
      chk(rs, HR_RETRY);
      pwrdn <= 1'b0;
      wr(`GFXCG_OFS_TILE_DATA, w);
      wt(gate_core, 1'b0);
      // enable low mid-settle: settling must not finish while frozen
      @(posedge clk_sys);
      ce <= 1'b0;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({greq, gate_core}, 2'b00);
      ce <= 1'b1;
      wt(gate_core, 1'b1);
      chk(mem.got.size(), exp_q.size());
      foreach (exp_q[i]) chk(mem.got[i], {exp_q[i][29], 3'h0, exp_q[i][28:0], exp_q[i]});
      ahb(1'b0, `GFXCG_OFS_STATUS, 32'h0);
      chk(rd, {30'h0, MD_IDLE});
      wrap_up();
   end
endmodule
`default_nettype wire
